// ### src/tick_watchdog_reset_sleep.sv
`timescale 1ns/1ps
// Notes on behaviour
// - tick rate from 16-bit stored divider.
// - one tick per four times divider cycles.
// - multi-byte settings stored low byte first.
// - watchdog period fixed at 2^16 ticks.
// - any character received outside sleep restarts watchdog.
// - armed nonzero vector redirects fetch after char.
// - event clears arm flag, releases held input.
// - default watchdog macro prints w.
// - reset command acts only on 5A.
// - reset discards characters buffered after it.
// - after reset, fetch starts at location 0.
// - default power-on macro sends greeting string.
// - sleep needs permit bit, clear by default.
// - sleep stops oscillator; watched pin wakes.
// - pause suspends execution, timing keeps running.
module tick_watchdog_reset_sleep
  import wd_pkg::*;
#(
  parameter int WAKE_COUNT = wd_pkg::WAKE_CYCLES,
  parameter int WD_BITS    = wd_pkg::WD_WIDTH
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      ce,
  // Configuration store write port (byte wide).
  input  wire logic                      cfg_we,
  input  wire logic [7:0]                cfg_addr,
  input  wire logic [7:0]                cfg_wdata,
  input  wire logic [7:0]                serial_config_byte,
  // Command side.
  input  wire logic                      rx_char,
  input  wire logic                      char_done,
  input  wire logic                      arm_set,
  input  wire logic                      reset_cmd,
  input  wire logic [7:0]                reset_arg,
  input  wire logic                      sleep_cmd,
  input  wire logic                      pause_req,
  input  wire logic                      wake_pin,
  // Outputs.
  output logic                           tick,
  output logic [wd_pkg::DIV_WIDTH-1:0]   tick_divider,
  output logic                           host_watchdog_arm,
  output logic                           fetch_load,
  output logic [7:0]                     fetch_addr,
  output logic                           release_held,
  output logic                           flush_rx,
  output logic                           soft_reset,
  output logic                           osc_stop,
  output logic                           exec_enable
);
  import wd_pkg::*;

  logic [7:0]   wd_vector;
  logic         sleep_permit;
  logic         expired;
  logic         wd_pending;
  logic         wake_s1;
  logic         wake_s2;
  logic         wake_s3;
  logic [31:0]  wake_count;
  power_state_t state;
  power_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Stored settings. The divider is assembled low byte at the lower location.
  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_divider <= TICK_DIV_DEFAULT;
      wd_vector    <= ZERO_VECTOR;
      sleep_permit <= 1'b0;
    end else if (ce) begin
      sleep_permit <= serial_config_byte[SLEEP_PERMIT_BIT];
      if (cfg_we && cfg_addr == CFG_DIV_LO) begin
        tick_divider[7:0] <= cfg_wdata;
      end
      if (cfg_we && cfg_addr == CFG_DIV_HI) begin
        tick_divider[15:8] <= cfg_wdata;
      end
      if (cfg_we && cfg_addr == CFG_WD_VECTOR) begin
        wd_vector <= cfg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing runs in RUN and PAUSED alike; only sleep stops the oscillator.
  logic run_ce;
  assign run_ce = ce && (state != SLEEP);

  tick_gen #(.WIDTH(DIV_WIDTH)) u_tick (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (run_ce),
    .divider (tick_divider),
    .tick    (tick)
  );

  // The period stays fixed in service; a narrower build only shortens tests.
  wd_counter #(.WIDTH(WD_BITS)) u_wd (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (run_ce),
    .tick    (tick),
    .rx_char (rx_char && state != SLEEP),
    .expired (expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arm flag: software sets; a taken event clears it. Set wins over clear.
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_watchdog_arm <= 1'b0;
    end else if (ce) begin
      if (arm_set) begin
        host_watchdog_arm <= 1'b1;
      end else if (expired && wd_vector != ZERO_VECTOR) begin
        host_watchdog_arm <= 1'b0;
      end
    end
  end

  // A taken event waits for the current character to finish.
  always_ff @(posedge mclk) begin
    if (reset) begin
      wd_pending <= 1'b0;
    end else if (ce) begin
      if (expired && host_watchdog_arm && wd_vector != ZERO_VECTOR) begin
        wd_pending <= 1'b1;
      end else if (char_done) begin
        wd_pending <= 1'b0;
      end
    end
  end

  // Unblock held input on the event itself; the default macro at the
  // vector prints w (WD_MACRO_CHAR), held in the store, not here.
  assign release_held = expired && host_watchdog_arm && (wd_vector != ZERO_VECTOR);

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset only with the key; it flushes the receive buffer.
  assign soft_reset = ce && reset_cmd && (reset_arg == SOFT_RESET_KEY);
  assign flush_rx   = soft_reset;

  // Fetch redirect: location 0 after any reset, vector after an event.
  always_ff @(posedge mclk) begin
    if (reset) begin
      fetch_load <= 1'b1;
      fetch_addr <= POR_VECTOR;
    end else if (ce) begin
      fetch_load <= 1'b0;
      if (soft_reset) begin
        fetch_load <= 1'b1;
        fetch_addr <= POR_VECTOR;
      end else if (wd_pending && char_done) begin
        fetch_load <= 1'b1;
        fetch_addr <= wd_vector;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin synchroniser; the third stage feeds the edge detector.
  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // Power state. Sleep is refused unless permitted; the wake wait covers
  // oscillator restart, during which execution stays off.
  always_comb begin
    next_state = state;
    case (state)
      RUN: begin
        if (sleep_cmd && sleep_permit) begin
          next_state = SLEEP;
        end else if (pause_req) begin
          next_state = PAUSED;
        end
      end
      PAUSED: begin
        if (!pause_req) begin
          next_state = RUN;
        end
      end
      SLEEP: begin
        if (wake_s2 != wake_s3) begin
          next_state = WAKE;
        end
      end
      WAKE: begin
        if (wake_count >= 32'(WAKE_COUNT - 1)) begin
          next_state = RUN;
        end
      end
      default: next_state = RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset || soft_reset) begin
      state <= RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Wake settle counter.
  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_count <= '0;
    end else if (ce) begin
      wake_count <= (state == WAKE) ? wake_count + 1'b1 : '0;
    end
  end

  assign osc_stop    = (state == SLEEP);
  assign exec_enable = (state == RUN);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_event_taken;
    expired && host_watchdog_arm && wd_vector != ZERO_VECTOR && !arm_set;
  endsequence

  // A sleeping part that sees a synchronised pin edge.
  sequence s_pin_edge;
    ce && !soft_reset && state == SLEEP && wake_s2 != wake_s3;
  endsequence

  // A pause that is still being requested.
  sequence s_pause_held;
    ce && !soft_reset && state == PAUSED && pause_req;
  endsequence

  a_arm_cleared: assert property (@(posedge mclk) disable iff (reset)
    (ce and s_event_taken) |=> !host_watchdog_arm)
    else $error("arm flag not cleared by event");

  // The redirect must wait for the current character, so it is remembered.
  a_event_pending: assert property (@(posedge mclk) disable iff (reset)
    (ce and s_event_taken) |=> wd_pending)
    else $error("taken event not held pending");

  // Held input is released in the very cycle that the event is taken.
  a_release_event: assert property (@(posedge mclk) disable iff (reset)
    release_held |-> (expired && host_watchdog_arm))
    else $error("held input released without event");
  a_redirect_fetch: assert property (@(posedge mclk) disable iff (reset)
    (ce && wd_pending && char_done && !soft_reset) |=> (fetch_load && fetch_addr == wd_vector))
    else $error("watchdog fetch not redirected");
  a_reset_key: assert property (@(posedge mclk) disable iff (reset)
    soft_reset |-> (reset_arg == SOFT_RESET_KEY))
    else $error("soft reset without key");
  a_reset_fetch: assert property (@(posedge mclk) disable iff (reset)
    soft_reset |=> (fetch_load && fetch_addr == POR_VECTOR))
    else $error("soft reset did not fetch from zero");

  // The low divider byte lands in the low half, at the lower location.
  a_divider_low: assert property (@(posedge mclk) disable iff (reset)
    (ce && cfg_we && cfg_addr == CFG_DIV_LO) |=> tick_divider[7:0] == $past(cfg_wdata))
    else $error("divider low byte misplaced");
  a_sleep_gated: assert property (@(posedge mclk) disable iff (reset)
    (ce && state == RUN && sleep_cmd && !sleep_permit && !pause_req && !soft_reset)
      |=> state == RUN)
    else $error("sleep entered without permit");
  a_pause_resume: assert property (@(posedge mclk) disable iff (reset)
    (ce && state == PAUSED && !pause_req && !soft_reset) |=> exec_enable)
    else $error("pause did not end at once");

  // Execution stays off for as long as the pause is requested.
  a_pause_hold: assert property (@(posedge mclk) disable iff (reset)
    s_pause_held |=> !exec_enable)
    else $error("executing during pause");

  // Timing must keep running while paused, or delays would stretch.
  a_pause_timing: assert property (@(posedge mclk) disable iff (reset)
    (state == PAUSED) |-> (run_ce == ce))
    else $error("timing stopped during pause");

  // A pin edge seen asleep starts the oscillator restart wait.
  a_wake_entry: assert property (@(posedge mclk) disable iff (reset)
    s_pin_edge |=> (state == WAKE))
    else $error("pin edge did not wake");

  // Nothing executes until the oscillator has had its settle time.
  a_wake_quiet: assert property (@(posedge mclk) disable iff (reset)
    (state == WAKE) |-> !exec_enable)
    else $error("executing before wake settled");
  a_osc_sleep: assert property (@(posedge mclk) disable iff (reset)
    osc_stop |-> !exec_enable)
    else $error("executing while asleep");
endmodule

// ### src/wd_pkg.sv
package wd_pkg;
  // Tick divider scale: one tick every four crystal cycles per divider count.
  localparam int          TICK_SCALE        = 4;
  localparam int          DIV_WIDTH         = 16;
  localparam logic [15:0] TICK_DIV_DEFAULT  = 16'h0E66;
  // Watchdog period in ticks (2^16).
  localparam int          WD_WIDTH          = 16;
  localparam logic [15:0] WD_LAST           = 16'hFFFF;
  // Soft reset argument.
  localparam logic [7:0]  SOFT_RESET_KEY    = 8'h5A;
  // Serial configuration byte: sleep permit bit.
  localparam int          SLEEP_PERMIT_BIT  = 6;
  localparam logic [7:0]  SERIAL_CFG_RESET  = 8'h00;
  // Command fetch addresses.
  localparam logic [7:0]  POR_VECTOR        = 8'h00;
  localparam logic [7:0]  ZERO_VECTOR       = 8'h00;
  // Configuration store: divider low byte at lower location.
  localparam logic [7:0]  CFG_DIV_LO        = 8'hF9;
  localparam logic [7:0]  CFG_DIV_HI        = 8'hFA;
  localparam logic [7:0]  CFG_WD_VECTOR     = 8'hFF;
  // Factory watchdog macro character.
  localparam logic [7:0]  WD_MACRO_CHAR     = 8'h77;
  // Wake settle time in ns and cycles at 10 ns.
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          WAKE_NS           = 10000000;
  localparam int          WAKE_CYCLES       = WAKE_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    RUN    = 4'b0001,
    PAUSED = 4'b0010,
    SLEEP  = 4'b0100,
    WAKE   = 4'b1000
  } power_state_t;
endpackage

// ### src/tick_gen.sv
`timescale 1ns/1ps
// Tick generator: a pulse every TICK_SCALE*divider crystal cycles.
module tick_gen
  import wd_pkg::*;
#(
  parameter int WIDTH = wd_pkg::DIV_WIDTH
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] divider,
  output logic                  tick
);
  logic [WIDTH+1:0] count;
  logic [WIDTH+1:0] limit;

  // A zero divider would stall; it is treated as one.
  assign limit = (divider == '0) ? (WIDTH+2)'(TICK_SCALE - 1)
                 : (WIDTH+2)'({divider, 2'b00} - 1'b1);

  // Count crystal cycles; tick registered.
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= (count >= limit);
      if (count >= limit) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  a_tick_period: assert property (@(posedge mclk) disable iff (reset)
    (ce && tick && divider == 16'h0001) |-> ##1 (ce |-> !tick))
    else $error("tick repeated too soon");
endmodule

// ### src/wd_counter.sv
`timescale 1ns/1ps
// Host activity counter: restarts on every received character, one event per expiry.
module wd_counter
  import wd_pkg::*;
#(
  parameter int WIDTH = wd_pkg::WD_WIDTH
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic rx_char,
  output logic      expired
);
  logic [WIDTH-1:0] count;
  logic             spent;

  // Counting, restart and the single-shot guard.
  always_ff @(posedge mclk) begin
    if (reset) begin
      count   <= '0;
      spent   <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (rx_char) begin
        count <= '0;
        spent <= 1'b0;
      end else if (tick && !spent) begin
        if (count == WIDTH'(WD_LAST)) begin
          expired <= 1'b1;
          spent   <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  a_single_event: assert property (@(posedge mclk) disable iff (reset)
    expired |=> !expired)
    else $error("watchdog fired twice in a row");
  a_rx_restart: assert property (@(posedge mclk) disable iff (reset)
    (ce && rx_char) |=> (count == '0))
    else $error("received char did not restart count");
endmodule

// ### tb/host_model.sv
`timescale 1ns/1ps
// Host side: command pulses last one cycle and change on the falling edge.
module host_model (
  input  wire logic  mclk,
  output logic       rx_char,
  output logic       reset_cmd,
  output logic [7:0] reset_arg,
  output logic       sleep_cmd,
  output logic       wake_pin
);
  // Idle levels; the argument shows garbage when no command is posted.
  initial begin
    rx_char   = 1'b0;
    reset_cmd = 1'b0;
    reset_arg = 8'hA5;
    sleep_cmd = 1'b0;
    wake_pin  = 1'b0;
  end
  // Post a reset command and leave it up so the caller can look at it.
  task automatic post_reset(input logic [7:0] arg);
    @(negedge mclk);
    reset_cmd = 1'b1;
    reset_arg = arg;
    #2;
  endtask
  // Drop the command, then stay quiet while the bridge restarts.
  task automatic end_reset();
    @(negedge mclk);
    reset_cmd = 1'b0;
    reset_arg = ~reset_arg;
    repeat (6) @(negedge mclk);
  endtask
  // One received character, which restarts the watchdog.
  task automatic send_char();
    @(negedge mclk);
    rx_char = 1'b1;
    @(negedge mclk);
    rx_char = 1'b0;
  endtask
  // Sleep request pulse.
  task automatic send_sleep();
    @(negedge mclk);
    sleep_cmd = 1'b1;
    @(negedge mclk);
    sleep_cmd = 1'b0;
  endtask
  // Toggle the handshake pin and send an all-ones character, which survives a half-lost start.
  task automatic wake();
    @(negedge mclk);
    wake_pin = ~wake_pin;
    rx_char  = 1'b1;
    @(negedge mclk);
    rx_char  = 1'b0;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wd_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        cfg_we = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [7:0]  cfg_wdata = 8'h00;
  logic [7:0]  serial_config_byte = 8'h00;
  logic        char_done = 1'b0;
  logic        arm_set = 1'b0;
  logic        pause_req = 1'b0;
  logic        rx_char, reset_cmd, sleep_cmd, wake_pin, tick, host_watchdog_arm;
  logic        fetch_load, release_held, flush_rx, soft_reset, osc_stop, exec_enable;
  logic [7:0]  reset_arg, fetch_addr;
  logic [15:0] tick_divider;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;

  always #5 mclk = ~mclk;

  host_model host_model_inst (.mclk(mclk), .rx_char(rx_char), .reset_cmd(reset_cmd),
    .reset_arg(reset_arg), .sleep_cmd(sleep_cmd), .wake_pin(wake_pin));

  // Short wake settle and a short watchdog so both fit in the run.
  tick_watchdog_reset_sleep #(.WAKE_COUNT(8), .WD_BITS(4)) tick_watchdog_reset_sleep_inst (
    .mclk(mclk), .reset(reset), .ce(1'b1), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .serial_config_byte(serial_config_byte), .rx_char(rx_char),
    .char_done(char_done), .arm_set(arm_set), .reset_cmd(reset_cmd),
    .reset_arg(reset_arg), .sleep_cmd(sleep_cmd), .pause_req(pause_req),
    .wake_pin(wake_pin), .tick(tick), .tick_divider(tick_divider),
    .host_watchdog_arm(host_watchdog_arm), .fetch_load(fetch_load),
    .fetch_addr(fetch_addr), .release_held(release_held), .flush_rx(flush_rx),
    .soft_reset(soft_reset), .osc_stop(osc_stop), .exec_enable(exec_enable));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it; an unknown bit matches only an unknown bit.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One byte into the configuration store.
  task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    cfg_we    = 1'b1;
    cfg_addr  = addr;
    cfg_wdata = data;
    @(negedge mclk);
    cfg_we    = 1'b0;
  endtask
  // Count tick pulses over a window of cycles.
  task automatic count_ticks(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      @(negedge mclk);
      if (tick === 1'b1) cnt++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; a lost wake counts as a mismatch and ends the run.
  initial begin
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    check("fetch_load", fetch_load, 16'h1);
    check("fetch_addr", fetch_addr, 16'h0);
    check("divider", tick_divider, 16'h0E66);
    check("arm", host_watchdog_arm, 16'h0);
    @(negedge mclk);
    check("fetch_load", fetch_load, 16'h0);
    $display("test reset done");
    cfg_write(CFG_DIV_LO, 8'h01);
    cfg_write(CFG_DIV_HI, 8'h00);
    @(negedge mclk);
    check("divider", tick_divider, 16'h0001);
    repeat (8) @(negedge mclk);
    count_ticks(40, n);
    check("ticks", n[15:0], 16'd10);
    cfg_write(CFG_WD_VECTOR, 8'h40);
    host_model_inst.send_char();
    arm_set = 1'b1;
    @(negedge mclk);
    arm_set = 1'b0;
    @(negedge mclk);
    check("arm", host_watchdog_arm, 16'h1);
    n = 0;
    while (release_held !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      final_report();
    end
    check("release_held", release_held, 16'h1);
    @(negedge mclk);
    check("arm", host_watchdog_arm, 16'h0);
    check("fetch_load", fetch_load, 16'h0);
    char_done = 1'b1;
    @(negedge mclk);
    char_done = 1'b0;
    check("fetch_load", fetch_load, 16'h1);
    check("fetch_addr", fetch_addr, 16'h40);
    n = 0;
    repeat (120) begin
      @(negedge mclk);
      if (release_held !== 1'b0) n++;
    end
    check("events", n[15:0], 16'h0);
    $display("test watchdog done");
    $display("test divider done");
    host_model_inst.post_reset(8'h12);
    check("soft_reset", soft_reset, 16'h0);
    host_model_inst.end_reset();
    host_model_inst.post_reset(SOFT_RESET_KEY);
    check("soft_reset", soft_reset, 16'h1);
    check("flush_rx", flush_rx, 16'h1);
    @(posedge mclk);
    #1;
    check("fetch_load", fetch_load, 16'h1);
    check("fetch_addr", fetch_addr, 16'h0);
    host_model_inst.end_reset();
    $display("test soft reset done");
    host_model_inst.send_sleep();
    check("osc_stop", osc_stop, 16'h0);
    serial_config_byte[SLEEP_PERMIT_BIT] = 1'b1;
    host_model_inst.send_sleep();
    check("osc_stop", osc_stop, 16'h1);
    check("exec_enable", exec_enable, 16'h0);
    host_model_inst.wake();
    n = 0;
    while (exec_enable !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      final_report();
    end
    check("osc_stop", osc_stop, 16'h0);
    $display("test sleep done");
    pause_req = 1'b1;
    @(negedge mclk);
    check("exec_enable", exec_enable, 16'h0);
    count_ticks(40, n);
    check("ticks", n[15:0], 16'd10);
    pause_req = 1'b0;
    @(negedge mclk);
    check("exec_enable", exec_enable, 16'h1);
    $display("test pause done");
    final_report();
  end
endmodule
